// ==== rtl/vkps_top.sv ====
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module vkps_top #(
    parameter int DEB_CYC = vkps_pkg::DEB_CYC,
    parameter int RPT_CYC = vkps_pkg::RPT_CYC,
    parameter int INIT_CYC = vkps_pkg::INIT_CYC,
    parameter int CW = vkps_pkg::CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [vkps_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire vkps_pkg::vkps_pins_t pins_i,
    input wire vkps_pkg::vkps_req_t req_i,
    output vkps_pkg::vkps_pout_t pins_o,
    output vkps_pkg::vkps_sts_t sts_o
);

    if (DEB_CYC < 1 || RPT_CYC < 1 || INIT_CYC < 1 || CW > 31 ||
        DEB_CYC >= 2 ** CW || RPT_CYC >= 2 ** CW || INIT_CYC >= 2 ** CW) begin : g_chk
        $error("vkps_top: counts do not fit the counter width.");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [vkps_pkg::NPIN-1:0] s1;
        logic [vkps_pkg::NPIN-1:0] s2;
        logic [vkps_pkg::NPIN-1:0] s3;
        logic [vkps_pkg::NPIN-1:0] flt;
        logic [2:0][CW-1:0] deb;
        logic [2:0] key;
        logic [CW-1:0] rpt;
        logic [CW-1:0] init;
        logic busy;
        logic rd_lat;
        logic wr_lat;
        logic modem_sw;
        logic alt_sw;
        logic muted;
        logic [vkps_pkg::VOL_W-1:0] vol;
        vkps_pkg::vkps_cfg_t cfg;
        vkps_pkg::vkps_gpo_t gpo;
        logic [vkps_pkg::BASE_W-1:0] modem_base;
        logic [vkps_pkg::BASE_W-1:0] alt_base;
        logic [vkps_pkg::PWR_W-1:0] pwr;
        logic [7:0] ldev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        vkps_pkg::vkps_pout_t po;
        vkps_pkg::vkps_sts_t so;
    } vkps_st_t;

    localparam vkps_st_t ST_RST = '{
        s1: vkps_pkg::SYNC_RST,
        s2: vkps_pkg::SYNC_RST,
        s3: vkps_pkg::SYNC_RST,
        flt: vkps_pkg::SYNC_RST,
        vol: vkps_pkg::VOL_RST,
        cfg: vkps_pkg::CFG_RST,
        so: '{master_mute: 1'b1, bus_isolated: 1'b1, master_atten: vkps_pkg::VOL_RST, default: '0},
        default: '0
    };

    vkps_st_t st_q;
    vkps_st_t st_d;
    logic [vkps_pkg::NPIN-1:0] agree;
    logic brst;
    logic bfall;
    logic [2:0] raw;
    logic [2:0] k;
    logic [2:0] ev;
    logic press;
    logic step;
    logic acc;
    logic err;
    logic [31:0] rv;
    vkps_pkg::vkps_stat_t stat;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        // Pins pass three flops; a level counts once the last two agree.
        st_d.s1 = pins_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        agree = ~(st_q.s2 ^ st_q.s3);
        st_d.flt = (st_q.s3 & agree) | (st_q.flt & ~agree);
        brst = st_d.flt[vkps_pkg::PIN_BRST];
        bfall = st_q.flt[vkps_pkg::PIN_BRST] & ~brst;

        // Key roles follow the enable and the mute style.
        raw = '0;
        if (st_q.cfg.volume_keys_enable) begin
            if (st_q.cfg.mute_style == vkps_pkg::MS_COMPAT) begin
                raw[vkps_pkg::K_UP] = ~st_q.flt[vkps_pkg::PIN_MUTE];
            end else begin
                raw[vkps_pkg::K_UP] = ~st_q.flt[vkps_pkg::PIN_UP];
            end
            raw[vkps_pkg::K_DN] = ~st_q.flt[vkps_pkg::PIN_DN];
            raw[vkps_pkg::K_MU] = ~st_q.cfg.mute_style[1] & ~st_q.flt[vkps_pkg::PIN_MUTE];
        end
        for (int i = 0; i < 3; i++) begin
            if (raw[i] == st_q.key[i]) begin
                st_d.deb[i] = '0;
            end else if (st_q.deb[i] >= CW'(DEB_CYC - 1)) begin
                st_d.deb[i] = '0;
                st_d.key[i] = raw[i];
            end else begin
                st_d.deb[i] = st_q.deb[i] + 1'b1;
            end
        end
        k = st_d.key;
        ev = k & ~st_q.key;
        press = ev[vkps_pkg::K_UP] | ev[vkps_pkg::K_DN];

        case (st_q.cfg.mute_style)
            vkps_pkg::MS_HOLD: begin
                st_d.muted = k[vkps_pkg::K_MU];
            end
            vkps_pkg::MS_TOGGLE: begin
                if (ev[vkps_pkg::K_MU]) begin
                    st_d.muted = ~st_q.muted;
                end else if (press) begin
                    st_d.muted = 1'b0;
                end
            end
            default: begin
                if (press && k[vkps_pkg::K_UP] && k[vkps_pkg::K_DN]) begin
                    st_d.muted = 1'b1;
                end else if (press) begin
                    st_d.muted = 1'b0;
                end
            end
        endcase

        // One key held alone steps at once and then at the repeat interval.
        step = 1'b0;
        if ((k[vkps_pkg::K_UP] ^ k[vkps_pkg::K_DN]) && !st_q.muted && !st_d.muted) begin
            if (press || st_q.rpt >= CW'(RPT_CYC - 1)) begin
                step = 1'b1;
                st_d.rpt = '0;
            end else begin
                st_d.rpt = st_q.rpt + 1'b1;
            end
        end else begin
            st_d.rpt = '0;
        end
        if (step) begin
            if (k[vkps_pkg::K_UP] && st_q.vol != '0) begin
                st_d.vol = st_q.vol - 1'b1;
            end else if (k[vkps_pkg::K_DN] && st_q.vol != vkps_pkg::VOL_MAX) begin
                st_d.vol = st_q.vol + 1'b1;
            end
        end

        // APB slave with one wait state; errors and read data settle first.
        stat = '0;
        stat.alt_sw = st_q.alt_sw;
        stat.modem_sw = st_q.modem_sw;
        stat.wr_lat = st_q.wr_lat;
        stat.rd_lat = st_q.rd_lat;
        stat.busy = st_q.busy;
        stat.brst = st_q.flt[vkps_pkg::PIN_BRST];
        stat.muted = st_q.muted;
        stat.vol = st_q.vol;
        err = 1'b0;
        case (paddr)
            vkps_pkg::ADDR_CFG: rv = 32'(st_q.cfg);
            vkps_pkg::ADDR_GPO: rv = 32'(st_q.gpo);
            vkps_pkg::ADDR_MODEM: rv = 32'(st_q.modem_base);
            vkps_pkg::ADDR_ALTCD: rv = 32'(st_q.alt_base);
            vkps_pkg::ADDR_PWR: rv = 32'(st_q.pwr);
            vkps_pkg::ADDR_LDEV: rv = 32'(st_q.ldev);
            vkps_pkg::ADDR_STAT: rv = 32'(stat);
            default: begin
                rv = '0;
                err = 1'b1;
            end
        endcase
        if (pwrite && (st_q.busy || brst)) begin
            err = 1'b1;
        end
        acc = psel & penable & st_q.pready;
        st_d.pready = psel & penable & ~st_q.pready;
        st_d.pslverr = st_d.pready & err;
        st_d.prdata = (st_d.pready && !pwrite && !err) ? rv : '0;
        if (acc && pwrite && !st_q.pslverr && !brst) begin
            case (paddr)
                vkps_pkg::ADDR_CFG: begin
                    st_d.cfg = vkps_pkg::vkps_cfg_t'(pwdata);
                    st_d.cfg.rsvd = '0;
                end
                vkps_pkg::ADDR_GPO: begin
                    st_d.gpo = vkps_pkg::vkps_gpo_t'(pwdata);
                    st_d.gpo.rsvd = '0;
                end
                vkps_pkg::ADDR_MODEM: begin
                    st_d.modem_base = pwdata[vkps_pkg::BASE_W-1:0];
                    if (pwdata[vkps_pkg::BASE_W-1:0] != '0 && !st_q.rd_lat) begin
                        st_d.modem_sw = 1'b1;
                    end
                end
                vkps_pkg::ADDR_ALTCD: begin
                    st_d.alt_base = pwdata[vkps_pkg::BASE_W-1:0];
                    if (pwdata[vkps_pkg::BASE_W-1:0] != '0) begin
                        st_d.alt_sw = 1'b1;
                    end
                end
                vkps_pkg::ADDR_PWR: st_d.pwr = pwdata[vkps_pkg::PWR_W-1:0];
                vkps_pkg::ADDR_LDEV: st_d.ldev = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // Bus reset holds the registers cleared; its fall starts initialisation.
        if (brst) begin
            st_d.cfg = '0;
            st_d.gpo = '0;
            st_d.modem_base = '0;
            st_d.alt_base = '0;
            st_d.pwr = '0;
            st_d.ldev = '0;
            st_d.modem_sw = 1'b0;
            st_d.alt_sw = 1'b0;
            st_d.busy = 1'b0;
            st_d.init = '0;
        end else if (bfall) begin
            st_d.rd_lat = st_q.flt[vkps_pkg::PIN_RD];
            st_d.wr_lat = st_q.flt[vkps_pkg::PIN_WR];
            st_d.busy = 1'b1;
            st_d.init = CW'(INIT_CYC - 1);
        end else if (st_q.busy) begin
            if (st_q.init == '0) begin
                st_d.busy = 1'b0;
                st_d.cfg = vkps_pkg::CFG_RST;
                st_d.gpo = '0;
                st_d.modem_base = '0;
                st_d.alt_base = '0;
                st_d.pwr = '0;
                st_d.ldev = '0;
                st_d.vol = vkps_pkg::VOL_RST;
                st_d.muted = 1'b0;
            end else begin
                st_d.init = st_q.init - 1'b1;
            end
        end

        // Pin functions.
        st_d.po = '0;
        st_d.so = '0;
        if (!st_q.cfg.volume_keys_enable) begin
            st_d.po.up_oe = 1'b1;
            st_d.po.up_o = req_i.synth_chip_select_n;
        end
        if (st_q.cfg.volume_keys_enable) begin
            st_d.po.down_o = 1'b1;
        end else if (st_q.alt_sw) begin
            st_d.po.down_oe = 1'b1;
            st_d.po.down_o = req_i.alt_cdrom_select_n;
        end else if (st_q.wr_lat) begin
            st_d.po.down_oe = st_q.gpo.gpo_en;
            st_d.po.down_o = st_q.gpo.gp_output_1;
        end else begin
            st_d.po.down_o = 1'b1;
            st_d.so.synth_irq_in = st_q.flt[vkps_pkg::PIN_DN];
        end
        if (st_q.gpo.eight_byte) begin
            st_d.po.gp0_oe = 1'b1;
            st_d.po.gp0_o = req_i.host_addr_bit2;
        end else begin
            st_d.po.gp0_oe = st_q.gpo.gpo_en;
            st_d.po.gp0_o = st_q.gpo.gp_output_0;
        end
        if (st_q.rd_lat) begin
            st_d.so.host_addr_hi = st_q.flt[vkps_pkg::PIN_CD+:4];
            st_d.so.host_addr_hi_valid = 1'b1;
        end else begin
            st_d.po.cd_oe = vkps_pkg::CD_OE_STD;
            st_d.po.cd_o = {2'h3, st_q.modem_sw ? req_i.modem_select_n : req_i.cd_dma_ack_n,
                            req_i.cd_select_n};
            st_d.so.cd_irq_in = st_q.flt[vkps_pkg::PIN_CD + vkps_pkg::CD_IRQ];
            if (st_q.modem_sw) begin
                st_d.so.modem_irq_in = st_q.flt[vkps_pkg::PIN_CD + vkps_pkg::CD_REQ];
            end else begin
                st_d.so.cd_dma_req = st_q.flt[vkps_pkg::PIN_CD + vkps_pkg::CD_REQ];
            end
        end
        st_d.so.master_mute = st_d.muted | brst | st_d.busy;
        st_d.so.master_atten = st_d.vol;
        st_d.so.power_down = st_d.pwr;
        st_d.so.device_enable = st_d.ldev;
        st_d.so.bus_isolated = st_d.cfg.iso;
        st_d.so.init_busy = st_d.busy;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign pins_o = st_q.po;
    assign sts_o = st_q.so;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    key_pins_a: assert property (st_q.cfg.volume_keys_enable |=>
        !st_q.po.up_oe && !st_q.po.down_oe) else $error("Key pins not inputs.");
    synth_cs_a: assert property (!st_q.cfg.volume_keys_enable |=> st_q.po.up_oe &&
        st_q.po.up_o == $past(req_i.synth_chip_select_n)) else $error("Chip select lost.");
    vol_range_a: assert property (st_q.vol <= vkps_pkg::VOL_MAX)
        else $error("Volume out of range.");
    vol_step_a: assert property ($changed(st_q.vol) && !$past(st_q.busy) |->
        st_q.vol == $past(st_q.vol) + 1'b1 || st_q.vol + 1'b1 == $past(st_q.vol))
        else $error("Volume moved more than one step.");
    hold_mute_a: assert property (st_q.cfg.volume_keys_enable && !st_q.busy &&
        st_q.cfg.mute_style == vkps_pkg::MS_HOLD |=> st_q.muted == st_q.key[vkps_pkg::K_MU])
        else $error("Held mute not followed.");
    hold_ignore_a: assert property (st_q.cfg.mute_style == vkps_pkg::MS_HOLD &&
        st_q.muted && !st_q.busy |=> $stable(st_q.vol)) else $error("Volume moved while muted.");
    toggle_a: assert property (st_q.cfg.mute_style == vkps_pkg::MS_TOGGLE && !st_q.busy &&
        !st_q.key[vkps_pkg::K_MU] ##1 st_q.key[vkps_pkg::K_MU] |-> $changed(st_q.muted))
        else $error("Mute press did not toggle.");
    two_key_a: assert property (st_q.cfg.mute_style[1] && !st_q.busy &&
        !(st_q.key[vkps_pkg::K_UP] && st_q.key[vkps_pkg::K_DN]) ##1
        (st_q.key[vkps_pkg::K_UP] && st_q.key[vkps_pkg::K_DN]) |-> st_q.muted)
        else $error("Both keys did not mute.");
    gp0_route_a: assert property (st_q.gpo.eight_byte |=> st_q.po.gp0_oe &&
        st_q.po.gp0_o == $past(req_i.host_addr_bit2)) else $error("Address bit not routed.");
    gpo_drive_a: assert property (!st_q.gpo.eight_byte && st_q.gpo.gpo_en |=>
        st_q.po.gp0_oe && st_q.po.gp0_o == $past(st_q.gpo.gp_output_0))
        else $error("General output not driven.");
    brst_mute_a: assert property (st_q.flt[vkps_pkg::PIN_BRST] |->
        st_q.so.master_mute && st_q.ldev == '0) else $error("Bus reset left outputs live.");
    strobe_latch_a: assert property ($fell(st_q.flt[vkps_pkg::PIN_BRST]) |-> st_q.busy &&
        st_q.rd_lat == $past(st_q.flt[vkps_pkg::PIN_RD]) &&
        st_q.wr_lat == $past(st_q.flt[vkps_pkg::PIN_WR])) else $error("Strobes not latched.");
    init_done_a: assert property ($fell(st_q.busy) && !st_q.flt[vkps_pkg::PIN_BRST] |->
        st_q.cfg.iso && st_q.vol == vkps_pkg::VOL_RST) else $error("Init end not isolated.");
    cd_addr_a: assert property (st_q.rd_lat |=> st_q.po.cd_oe == '0 &&
        st_q.so.host_addr_hi == $past(st_q.flt[vkps_pkg::PIN_CD+:4]))
        else $error("CD pins not address inputs.");
    modem_keep_a: assert property (st_q.modem_sw ##1 !st_q.flt[vkps_pkg::PIN_BRST] |->
        st_q.modem_sw) else $error("Modem pins reverted.");
    alt_pin_a: assert property (!st_q.cfg.volume_keys_enable && st_q.alt_sw |=>
        st_q.po.down_oe && st_q.po.down_o == $past(req_i.alt_cdrom_select_n))
        else $error("Alternate select not driven.");

endmodule

`default_nettype wire

// ==== rtl/vkps_pkg.sv ====
package vkps_pkg;
    // Timing figures and the clock rate they are counted in.
    localparam int CLK_KHZ = 40000;
    localparam int DEBOUNCE_MS = 5;
    localparam int REPEAT_MS = 200;
    localparam int INIT_MS = 1500;
    localparam int DEB_CYC = DEBOUNCE_MS * CLK_KHZ;
    localparam int RPT_CYC = REPEAT_MS * CLK_KHZ;
    localparam int INIT_CYC = INIT_MS * CLK_KHZ;
    localparam int CNT_W = 26;

    // Master volume: index 0 is the loudest setting, each index one step quieter.
    localparam int VOL_TOP_DB = 12;
    localparam int VOL_BOT_DB = -36;
    localparam int VOL_STEP_DB = 2;
    localparam int VOL_W = 5;
    localparam logic [VOL_W-1:0] VOL_MAX = VOL_W'((VOL_TOP_DB - VOL_BOT_DB) / VOL_STEP_DB);
    localparam logic [VOL_W-1:0] VOL_RST = VOL_W'(VOL_TOP_DB / VOL_STEP_DB);

    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] ADDR_CFG = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_GPO = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_MODEM = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_ALTCD = 8'h0C;
    localparam logic [APB_AW-1:0] ADDR_PWR = 8'h10;
    localparam logic [APB_AW-1:0] ADDR_LDEV = 8'h14;
    localparam logic [APB_AW-1:0] ADDR_STAT = 8'h18;
    localparam int BASE_W = 16;
    localparam int PWR_W = 8;

    // Positions of the pin inputs in the synchroniser vector.
    localparam int NPIN = 10;
    localparam logic [NPIN-1:0] SYNC_RST = 10'h3FE;
    localparam int PIN_BRST = 0;
    localparam int PIN_RD = 1;
    localparam int PIN_WR = 2;
    localparam int PIN_MUTE = 3;
    localparam int PIN_UP = 4;
    localparam int PIN_DN = 5;
    localparam int PIN_CD = 6;
    localparam int CD_IRQ = 2;
    localparam int CD_REQ = 3;
    localparam logic [3:0] CD_OE_STD = 4'h3;

    localparam int K_UP = 0;
    localparam int K_DN = 1;
    localparam int K_MU = 2;
    localparam logic [1:0] MS_HOLD = 2'h0;
    localparam logic [1:0] MS_TOGGLE = 2'h1;
    localparam logic [1:0] MS_COMPAT = 2'h3;

    typedef struct packed {
        logic [3:0] cd_pins;
        logic down_pin_n;
        logic up_pin_n;
        logic mute_key_n;
        logic ext_io_write_strobe_n;
        logic ext_io_read_strobe_n;
        logic bus_reset_drive;
    } vkps_pins_t;

    typedef struct packed {
        logic synth_chip_select_n;
        logic alt_cdrom_select_n;
        logic cd_select_n;
        logic cd_dma_ack_n;
        logic modem_select_n;
        logic host_addr_bit2;
    } vkps_req_t;

    typedef struct packed {
        logic up_o;
        logic up_oe;
        logic down_o;
        logic down_oe;
        logic [3:0] cd_o;
        logic [3:0] cd_oe;
        logic gp0_o;
        logic gp0_oe;
    } vkps_pout_t;

    typedef struct packed {
        logic synth_irq_in;
        logic cd_irq_in;
        logic cd_dma_req;
        logic modem_irq_in;
        logic [3:0] host_addr_hi;
        logic host_addr_hi_valid;
        logic master_mute;
        logic [VOL_W-1:0] master_atten;
        logic [PWR_W-1:0] power_down;
        logic [7:0] device_enable;
        logic bus_isolated;
        logic init_busy;
    } vkps_sts_t;

    typedef struct packed {
        logic [27:0] rsvd;
        logic iso;
        logic [1:0] mute_style;
        logic volume_keys_enable;
    } vkps_cfg_t;

    typedef struct packed {
        logic [27:0] rsvd;
        logic eight_byte;
        logic gpo_en;
        logic gp_output_1;
        logic gp_output_0;
    } vkps_gpo_t;

    typedef struct packed {
        logic [19:0] rsvd;
        logic alt_sw;
        logic modem_sw;
        logic wr_lat;
        logic rd_lat;
        logic busy;
        logic brst;
        logic muted;
        logic [VOL_W-1:0] vol;
    } vkps_stat_t;

    localparam vkps_cfg_t CFG_RST = '{iso: 1'b1, default: '0};
endpackage

// ==== sim/vkps_switches.sv ====
`timescale 1ns/10ps
`default_nettype none
// Pulled-up buttons that bounce for three cycles after a change, plus host strobes.
module vkps_switches (
    input wire logic pclk,
    input wire logic [2:0] press,
    input wire logic [6:0] host,
    input wire vkps_pkg::vkps_pout_t pins_o,
    output var vkps_pkg::vkps_pins_t pins_i
);
    logic [2:0] last_q = '0, chg_q = '0, key_n;
    logic [1:0] bnc_q = '0;
    always_ff @(posedge pclk) begin
        last_q <= press;
        chg_q <= (press != last_q) ? press ^ last_q : chg_q;
        bnc_q <= (press != last_q) ? 2'h3 : bnc_q - 2'(bnc_q != 2'h0);
    end
    assign key_n = ~last_q ^ (chg_q & {3{bnc_q[0]}});
    always_comb begin
        pins_i = vkps_pkg::vkps_pins_t'({7'h00, host[2:0]});
        pins_i.cd_pins = (pins_o.cd_oe & pins_o.cd_o) | (~pins_o.cd_oe & host[6:3]);
        pins_i.up_pin_n = pins_o.up_oe ? pins_o.up_o : key_n[vkps_pkg::K_UP];
        pins_i.down_pin_n = pins_o.down_oe ? pins_o.down_o : key_n[vkps_pkg::K_DN];
        pins_i.mute_key_n = key_n[vkps_pkg::K_MU];
    end
endmodule
`default_nettype wire

// ==== sim/volume_keys_and_pin_select_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module volume_keys_and_pin_select_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, er;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, v, seed = 32'hD57D6AAC;
    logic [2:0] press = '0;
    logic [6:0] host = '0;
    logic [4:0][7:0] watch;
    logic [19:0] stp [13];
    vkps_pkg::vkps_req_t req_i = '0;
    vkps_pkg::vkps_pins_t pins_i;
    vkps_pkg::vkps_pout_t pins_o;
    vkps_pkg::vkps_sts_t sts_o;
    int n_fail = 0, num_checks = 0;
    always #12.5 pclk = ~pclk;
    assign watch = {8'(sts_o.host_addr_hi), 7'h0, pins_o.down_oe, 7'h0, sts_o.init_busy,
        7'h0, sts_o.master_mute, 8'(sts_o.master_atten)};
    vkps_top #(.DEB_CYC(4), .RPT_CYC(20), .INIT_CYC(50)) i_vkps_top (.*);
    vkps_switches i_vkps_switches (.*);
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Pin enable and the level it carries while enabled.
    function automatic logic [1:0] exp_gp0(input logic [31:0] x);
        return x[3] ? {1'b1, x[26]} : {x[2], x[0] & x[2]};
    endfunction
    task automatic wt(input int s, input logic [31:0] e, input int lim);
        int n = 0;
        while (32'(watch[s]) !== e && ++n < lim) @(posedge pclk);
        chk(32'(watch[s]), e);
        if (32'(watch[s]) !== e) stop_test();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(pready), 32'h1);
        if (pready !== 1'b1) stop_test();
        @(posedge pclk);
    endtask
    initial begin
        stp = '{20'h11051, 20'h12061,
            20'h15111, 20'h10101, 20'h10060,
            20'h11000,
            20'h11001,
            20'h34111, 20'h31101,
            20'h53111, 20'h51101,
            20'h72011, 20'h74000};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'({sts_o.master_atten, pins_o.up_oe, pins_o.cd_oe}),
            32'({vkps_pkg::VOL_RST, 1'b1, vkps_pkg::CD_OE_STD}));
        apb(1'b1, 8'h08, 32'h2F8);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(rd[10]), 32'h1);
        req_i <= vkps_pkg::vkps_req_t'(6'h02);
        repeat (2) @(posedge pclk);
        chk(32'(pins_o.cd_o[1:0]), 32'h2);
        v = lfsr();
        apb(1'b1, 8'h10, v);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'(v[7:0]));
        chk(32'(sts_o.power_down), 32'(v[7:0]));
        apb(1'b0, 8'h1C, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, 8'h14, 32'hFF);
        $display("test reset over");
        host <= 7'h03;
        repeat (8) @(posedge pclk);
        chk(32'({sts_o.master_mute, sts_o.device_enable}), 32'h100);
        host <= 7'h02;
        wt(2, 32'h1, 20);
        wt(2, 32'h0, 80);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'({sts_o.bus_isolated, rd[9:8]}), 32'h5);
        chk(32'({pins_o.cd_oe, pins_o.down_oe, sts_o.synth_irq_in, sts_o.host_addr_hi_valid}),
            32'h3);
        v = lfsr();
        host <= {v[3:0], 3'h2};
        wt(4, 32'(v[3:0]), 10);
        apb(1'b1, 8'h0C, 32'h170);
        wt(3, 32'h1, 8);
        $display("test bus reset over");
        foreach (stp[i]) begin
            apb(1'b1, 8'h00, 32'(stp[i][19:16]));
            press <= stp[i][14:12];
            // Released keys clear before the first repeat, so each released press steps at most once; a held one repeats.
            repeat (16) @(posedge pclk);
            wt(int'(stp[i][11:8]), 32'(stp[i][7:4]), 250);
            press <= stp[i][0] ? 3'h0 : press;
            repeat (25) @(posedge pclk);
        end
        $display("test keys over");
        for (int i = 0; i < 6; i++) begin
            v = lfsr();
            req_i <= vkps_pkg::vkps_req_t'(v[31:26]);
            apb(1'b1, 8'h04, 32'(v[3:0]));
            repeat (3) @(posedge pclk);
            chk(32'({pins_o.gp0_oe, pins_o.gp0_o & pins_o.gp0_oe}), 32'(exp_gp0(v)));
        end
        $display("test outputs over");
        stop_test();
    end
endmodule
`default_nettype wire
